// >>> include/nvsram_seq_pkg.sv
// constants, timing counts and carrier types for the store/recall sequencer
// assumes a single 50 MHz clock; all times are turned into cycle counts here
package nvsram_seq_pkg;

    // clock period in ns
    localparam int CLK_PERIOD_NS = 20;

    // printed times, in their own units
    localparam int WRITE_GRACE_NS = 25;
    localparam int STORE_PIN_PULSE_NS = 15;
    localparam int SOFT_CMD_PROCESS_US = 500;
    localparam int PIN_RELEASE_US = 5;
    localparam int SLEEP_ENTER_MS = 8;
    localparam int WAKE_MS = 20;
    localparam int WAKE_LOWEST_MS = 40;
    localparam int STANDBY_US = 100;

    // longest times round down, never below one cycle
    function automatic int floor_cycles(input longint ns);
        longint c;
        c = ns / CLK_PERIOD_NS;
        return (c < 1) ? 1 : int'(c);
    endfunction

    // least times round up, never below one cycle
    function automatic int ceil_cycles(input longint ns);
        longint c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : int'(c);
    endfunction

    localparam int GRACE_CYCLES = floor_cycles(longint'(WRITE_GRACE_NS));
    localparam int PIN_PULSE_CYCLES = ceil_cycles(longint'(STORE_PIN_PULSE_NS));
    localparam int SOFT_CMD_CYCLES =
        floor_cycles(longint'(SOFT_CMD_PROCESS_US) * 1000);
    localparam int PIN_RELEASE_CYCLES =
        floor_cycles(longint'(PIN_RELEASE_US) * 1000);
    localparam int SLEEP_CYCLES =
        floor_cycles(longint'(SLEEP_ENTER_MS) * 1000000);
    localparam int WAKE_CYCLES = floor_cycles(longint'(WAKE_MS) * 1000000);
    localparam int WAKE_LOWEST_CYCLES =
        floor_cycles(longint'(WAKE_LOWEST_MS) * 1000000);
    localparam int STANDBY_CYCLES =
        floor_cycles(longint'(STANDBY_US) * 1000);
    // release timer load; sync flops and the decision eat four cycles
    localparam int PIN_RELEASE_LOAD = PIN_RELEASE_CYCLES - 4;

    // timer width covers the longest count (2,000,000)
    localparam int TIMER_W = 22;

    // values after reset, and depth of the own-drive echo on the store pin
    localparam bit AUTOSAVE_EN_RST = 1'b1;
    localparam bit LOW_VOLTAGE_RST = 1'b1;
    localparam bit STORE_PIN_RST = 1'b1;
    localparam int ECHO_W = 3;

    // software commands handed over by the bus engine
    typedef enum logic [2:0] {
        CMD_STORE,
        CMD_RECALL,
        CMD_SLEEP,
        CMD_AUTOSAVE_ON,
        CMD_AUTOSAVE_OFF
    } soft_cmd_t;

    // requests from the bus engine, same clock
    typedef struct packed {
        logic cmdValid;
        soft_cmd_t cmd;
        logic sramWrite;
        logic busStop;
        logic wakeReq;
    } host_req_t;

    // status toward the bus engine and the array
    typedef struct packed {
        logic hostAccessEn;
        logic sramWriteEn;
        logic standby;
        logic asleep;
        logic writePending;
        logic autosaveEn;
    } host_stat_t;

endpackage

// >>> logic/nvsram_store_recall_sequencer.sv
// sequencer for store, recall, sleep, wake and standby of a serial nvsram
// assumes a bus engine on mclk that hands over decoded commands and a
// cell array that pulses nvDone when a store or recall has finished
`timescale 1ns/1ps

// How it works
// (RQ1) a power-loss or pin store is skipped when nothing was written since the last nonvolatile operation.
// (RQ2) on a power-loss or pin store trigger, sram writes stay enabled for the grace time before the store starts.
// (RQ3) host reads and writes are refused during store, recall and while supply is below the trip level.
// (RQ4) store and recall commands keep host access locked until the operation finishes.
// (RQ5) a software command is acted on no later than the software processing time after it arrives.
// (RQ6) whoever asks for a pin store holds the store pin low for at least 15 ns.
// (RQ7) sram access stays off as long as the store pin is held low from outside.
// (RQ8) when not signalling busy, the store pin driver is off and only the pull-up holds the line.
// (RQ9) host access returns within 5 us after the store pin goes high.
// (RQ10) after a sleep command the low-power state is entered within 8 ms; the code starts the 8 ms count only after the software processing time.
// (RQ11) after a wake request access returns within 20 ms, or 40 ms on the lowest-voltage variant.
// (RQ12) after a bus stop the standby state is entered within 100 us.
// (RQ13) a write-pending flag is set by any sram write and cleared when a store or recall completes.
module nvsram_store_recall_sequencer import nvsram_seq_pkg::*; #(
    parameter bit LOWEST_VDD_VARIANT = 1'b0,
    parameter int SOFT_CMD_CYC = SOFT_CMD_CYCLES,
    parameter int SLEEP_CYC = SLEEP_CYCLES,
    parameter int WAKE_CYC = WAKE_CYCLES,
    parameter int WAKE_LOWEST_CYC = WAKE_LOWEST_CYCLES,
    parameter int STANDBY_CYC = STANDBY_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // bus engine side
    input wire host_req_t hostReq,
    output host_stat_t hostStat,
    // supply monitor pin, high while supply is below the trip level
    input wire logic lowVoltageTrip,
    // open-drain store pin, active low
    input wire logic hwStoreBusyNIn,
    output logic hwStoreBusyNOut,
    output logic hwStoreBusyNOe,
    // cell array
    output logic nvStoreStart,
    output logic nvRecallStart,
    input wire logic nvDone
);
    typedef enum logic [3:0] {
        ST_IDLE, ST_CMD, ST_GRACE, ST_STORE, ST_RECALL, ST_PIN_HOLD,
        ST_PIN_RELEASE, ST_LOWV, ST_SLEEP_ENTER, ST_ASLEEP, ST_WAKE
    } seq_state_t;

    typedef enum logic [1:0] {SRC_SOFT, SRC_PIN, SRC_POWER} store_src_t;
    localparam int WAKE_USE =
        LOWEST_VDD_VARIANT ? WAKE_LOWEST_CYC : WAKE_CYC;
    seq_state_t state_reg, state_next;
    store_src_t src_reg, src_next;
    soft_cmd_t cmd_reg, cmd_next;
    logic [TIMER_W-1:0] timer_reg, timer_next;
    logic [TIMER_W-1:0] stbCnt_reg;
    logic stbArmed_reg, standby_reg;
    logic pending_reg, autosave_reg;
    logic storeGo, recallGo;
    logic [ECHO_W-1:0] echo_reg;
    logic accessEn_reg, writeEn_reg, asleep_reg, drive_reg;
    logic lowVoltage, pinSync;

    // supply monitor and store pin come from outside
    sync_2ff #(.RST_VAL(LOW_VOLTAGE_RST)) u_sync_lowv (
        .mclk(mclk),
        .rst(rst),
        .asyncIn(lowVoltageTrip),
        .syncOut(lowVoltage)
    );
    sync_2ff #(.RST_VAL(STORE_PIN_RST)) u_sync_pin (
        .mclk(mclk),
        .rst(rst),
        .asyncIn(hwStoreBusyNIn),
        .syncOut(pinSync)
    );

    // decode of pin, timer and triggers
    wire ownEcho = drive_reg | (|echo_reg); // own drive still visible
    wire pinLow = ~pinSync & ~ownEcho;
    wire timerZero = (timer_reg == '0);
    wire powerStore = pending_reg & autosave_reg; // see (RQ1)
    wire pinStore = pending_reg; // see (RQ1)
    wire nvBusy = (state_reg == ST_STORE) | (state_reg == ST_RECALL);
    wire nvFinish = nvBusy & nvDone;
    wire accessNext = (state_next == ST_IDLE) & ~pinLow & ~lowVoltage;
    wire writeEnNext = accessNext | (state_next == ST_GRACE);
    wire driveNext = (state_next == ST_GRACE) | (state_next == ST_STORE);
    wire hostActive = hostReq.cmdValid | hostReq.sramWrite;

    // sequencing of operations
    always_comb begin
        state_next = state_reg;
        src_next = src_reg;
        cmd_next = cmd_reg;
        timer_next = timerZero ? timer_reg : timer_reg - 1'b1;
        storeGo = 1'b0;
        recallGo = 1'b0;
        unique case (state_reg)
            ST_IDLE: begin
                if (lowVoltage) begin
                    src_next = SRC_POWER;
                    if (powerStore) begin
                        state_next = ST_GRACE; // see (RQ2)
                        timer_next = TIMER_W'(GRACE_CYCLES - 1);
                    end else begin
                        state_next = ST_LOWV; // see (RQ1)
                    end
                end else if (pinLow) begin
                    src_next = SRC_PIN;
                    if (pinStore) begin
                        state_next = ST_GRACE; // see (RQ2)
                        timer_next = TIMER_W'(GRACE_CYCLES - 1);
                    end else begin
                        state_next = ST_PIN_HOLD; // see (RQ1)
                    end
                end else if (hostReq.cmdValid) begin
                    cmd_next = hostReq.cmd;
                    state_next = ST_CMD;
                    timer_next = TIMER_W'(SOFT_CMD_CYC - 1); // see (RQ5)
                end
            end
            ST_CMD: begin
                if (lowVoltage) begin
                    state_next = ST_LOWV;
                end else if (timerZero) begin
                    unique case (cmd_reg)
                        CMD_STORE: begin
                            storeGo = 1'b1;
                            src_next = SRC_SOFT;
                            state_next = ST_STORE; // see (RQ4)
                        end
                        CMD_RECALL: begin
                            recallGo = 1'b1;
                            state_next = ST_RECALL; // see (RQ4)
                        end
                        CMD_SLEEP: begin
                            state_next = ST_SLEEP_ENTER;
                            timer_next = TIMER_W'(SLEEP_CYC - 1);
                        end
                        default: state_next = ST_IDLE;
                    endcase
                end
            end
            ST_GRACE: begin
                if (timerZero) begin
                    storeGo = 1'b1;
                    state_next = ST_STORE;
                end
            end
            ST_STORE: begin
                if (nvDone) begin
                    unique case (src_reg)
                        SRC_PIN: state_next = ST_PIN_HOLD;
                        SRC_POWER: state_next = ST_LOWV;
                        default: state_next = ST_IDLE;
                    endcase
                end
            end
            ST_RECALL: begin
                if (nvDone) begin
                    state_next = ST_IDLE;
                end
            end
            ST_PIN_HOLD: begin
                if (!pinLow) begin
                    state_next = ST_PIN_RELEASE; // see (RQ7)
                    timer_next = TIMER_W'(PIN_RELEASE_LOAD); // see (RQ9)
                end
            end
            ST_PIN_RELEASE: begin
                if (pinLow) begin
                    state_next = ST_PIN_HOLD;
                end else if (timerZero) begin
                    state_next = ST_IDLE; // see (RQ9)
                end
            end
            ST_LOWV: begin
                if (!lowVoltage) begin
                    recallGo = 1'b1;
                    state_next = ST_RECALL;
                end
            end
            ST_SLEEP_ENTER: begin
                if (timerZero) begin
                    state_next = ST_ASLEEP; // see (RQ10)
                end
            end
            ST_ASLEEP: begin
                if (lowVoltage) begin
                    state_next = ST_LOWV;
                end else if (hostReq.wakeReq) begin
                    state_next = ST_WAKE;
                    timer_next = TIMER_W'(WAKE_USE - 1); // see (RQ11)
                end
            end
            ST_WAKE: begin
                if (timerZero) begin
                    state_next = ST_IDLE; // see (RQ11)
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // state, timer and command
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_LOWV;
            src_reg <= SRC_SOFT;
            cmd_reg <= CMD_STORE;
            timer_reg <= '0;
        end else begin
            state_reg <= state_next;
            src_reg <= src_next;
            cmd_reg <= cmd_next;
            timer_reg <= timer_next;
        end
    end

    // write-pending and autosave flags; a new write beats the clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pending_reg <= 1'b0;
            autosave_reg <= AUTOSAVE_EN_RST;
        end else begin
            if (hostReq.sramWrite && writeEn_reg) begin
                pending_reg <= 1'b1; // see (RQ13)
            end else if (nvFinish) begin
                pending_reg <= 1'b0; // see (RQ13)
            end
            if (state_reg == ST_CMD && timerZero && !lowVoltage) begin
                if (cmd_reg == CMD_AUTOSAVE_ON) begin
                    autosave_reg <= 1'b1;
                end else if (cmd_reg == CMD_AUTOSAVE_OFF) begin
                    autosave_reg <= 1'b0;
                end
            end
        end
    end

    // standby timer started by a bus stop while idle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stbCnt_reg <= '0;
            stbArmed_reg <= 1'b0;
            standby_reg <= 1'b0;
        end else if (state_reg != ST_IDLE || hostActive) begin
            stbArmed_reg <= 1'b0;
            standby_reg <= 1'b0;
        end else if (hostReq.busStop) begin
            stbCnt_reg <= TIMER_W'(STANDBY_CYC - 1); // see (RQ12)
            stbArmed_reg <= 1'b1;
            standby_reg <= 1'b0;
        end else if (stbArmed_reg) begin
            if (stbCnt_reg == '0) begin
                standby_reg <= 1'b1; // see (RQ12)
                stbArmed_reg <= 1'b0;
            end else begin
                stbCnt_reg <= stbCnt_reg - 1'b1;
            end
        end
    end

    // registered outputs
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            accessEn_reg <= 1'b0;
            writeEn_reg <= 1'b0;
            asleep_reg <= 1'b0;
            drive_reg <= 1'b0;
            echo_reg <= '0;
            nvStoreStart <= 1'b0;
            nvRecallStart <= 1'b0;
        end else begin
            accessEn_reg <= accessNext; // see (RQ3) (RQ4) (RQ7)
            writeEn_reg <= writeEnNext; // see (RQ2)
            asleep_reg <= (state_next == ST_ASLEEP);
            drive_reg <= driveNext; // see (RQ8)
            echo_reg <= {echo_reg[ECHO_W-2:0], drive_reg};
            nvStoreStart <= storeGo;
            nvRecallStart <= recallGo;
        end
    end

    // status carrier and open-drain pin
    assign hostStat = '{
        hostAccessEn: accessEn_reg,
        sramWriteEn: writeEn_reg,
        standby: standby_reg,
        asleep: asleep_reg,
        writePending: pending_reg,
        autosaveEn: autosave_reg
    };
    assign hwStoreBusyNOut = 1'b0; // only ever pulls low
    assign hwStoreBusyNOe = drive_reg; // see (RQ8)
endmodule

// >>> logic/sync_2ff.sv
// two-flop synchroniser for a level arriving from outside the clock domain
// assumes the level is slow compared with the clock
`timescale 1ns/1ps
module sync_2ff #(
    parameter bit RST_VAL = 1'b0
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // level in and synchronised level out
    input wire logic asyncIn,
    output logic syncOut
);
    logic meta_reg;

    // first flop feeds only the second
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta_reg <= RST_VAL;
            syncOut <= RST_VAL;
        end else begin
            meta_reg <= asyncIn;
            syncOut <= meta_reg;
        end
    end
endmodule

// >>> verif/nv_cell_model.sv
// cell array stand-in: answers each store or recall start with done
// assumes start pulses last one cycle and never overlap
`timescale 1ns/1ps
module nv_cell_model #(
    parameter int FAST_CYC = 3,
    parameter int SLOW_CYC = 40
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // array requests and answer
    input wire logic slow,
    input wire logic storeStart,
    input wire logic recallStart,
    output logic done
);
    int cnt_reg;

    // count down from a start, one-cycle done at the end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 0;
            done <= 1'b0;
        end else begin
            done <= (cnt_reg == 1);
            if (storeStart || recallStart) begin
                cnt_reg <= slow ? SLOW_CYC : FAST_CYC;
            end else if (cnt_reg != 0) begin
                cnt_reg <= cnt_reg - 1;
            end
        end
    end
endmodule

// >>> verif/nvsram_seq_sva.sv
// checker for the store/recall sequencer, sees only its ports
// assumes it is bound into every instance of the sequencer
`timescale 1ns/1ps
module nvsram_seq_sva
    import nvsram_seq_pkg::*;
#(
    parameter bit LOWEST_VDD_VARIANT = 1'b0,
    parameter int SOFT_CMD_CYC = 8,
    parameter int SLEEP_CYC = 16,
    parameter int WAKE_CYC = 16,
    parameter int WAKE_LOWEST_CYC = 32,
    parameter int STANDBY_CYC = 10
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // bus engine side
    input wire host_req_t hostReq,
    input wire host_stat_t hostStat,
    // pins and cell array
    input wire logic lowVoltageTrip,
    input wire logic hwStoreBusyNIn,
    input wire logic hwStoreBusyNOut,
    input wire logic hwStoreBusyNOe,
    input wire logic nvStoreStart,
    input wire logic nvRecallStart,
    input wire logic nvDone
);
    localparam int CMD_LAT = SOFT_CMD_CYC + 1;
    localparam int SLP_LAT = SOFT_CMD_CYC + SLEEP_CYC + 3;
    localparam int WK_LAT =
        (LOWEST_VDD_VARIANT ? WAKE_LOWEST_CYC : WAKE_CYC) + 2;
    logic softArm_reg;
    logic [7:0] sbCnt_reg;
    logic [7:0] sbCnt_next;
    logic take;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // command taken, quiet-time counter after a stop
    assign take = hostReq.cmdValid && hostStat.hostAccessEn;
    assign sbCnt_next =
        (hostReq.cmdValid || hostReq.sramWrite || !hostStat.hostAccessEn)
        ? 8'h00 : hostReq.busStop ? 8'h01
        : (sbCnt_reg != 8'h00 && sbCnt_reg != 8'hff) ? sbCnt_reg + 8'h01
        : sbCnt_reg;

    // remember a soft store until its start pulse
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            softArm_reg <= 1'b0;
            sbCnt_reg <= 8'h00;
        end else begin
            softArm_reg <= (take && hostReq.cmd == CMD_STORE)
                || (softArm_reg && !nvStoreStart);
            sbCnt_reg <= sbCnt_next;
        end
    end

    a_pin_drive_busy: assert property (hwStoreBusyNOe |->
        !hostStat.hostAccessEn && !hwStoreBusyNOut) else $error("pin drive");
    a_cmd_lock_out: assert property (take && (hostReq.cmd == CMD_STORE ||
        hostReq.cmd == CMD_RECALL) |=> !hostStat.hostAccessEn [*8])
        else $error("cmd lock");
    a_store_cmd_time: assert property (take && hostReq.cmd == CMD_STORE
        |-> ##[1:CMD_LAT] nvStoreStart) else $error("store late");
    a_recall_cmd_time: assert property (take && hostReq.cmd == CMD_RECALL
        |-> ##[1:CMD_LAT] nvRecallStart) else $error("recall late");
    a_nv_op_lock: assert property ((nvStoreStart || nvRecallStart)
        |=> !hostStat.hostAccessEn [*2]) else $error("nv lock");
    a_low_supply_off: assert property (lowVoltageTrip [*6]
        |-> !hostStat.hostAccessEn) else $error("low supply access");
    a_pin_low_off: assert property (!hwStoreBusyNIn [*6]
        |-> !hostStat.hostAccessEn) else $error("pin low access");
    a_skip_clean_store: assert property (nvStoreStart && !softArm_reg
        |-> hostStat.writePending) else $error("clean store");
    a_pending_on_write: assert property (hostReq.sramWrite
        && hostStat.sramWriteEn |=> hostStat.writePending)
        else $error("pending not set");
    a_sleep_enter_time: assert property (take && hostReq.cmd == CMD_SLEEP
        |-> ##[1:SLP_LAT] hostStat.asleep) else $error("sleep late");
    a_wake_up_time: assert property (hostStat.asleep && hostReq.wakeReq
        |-> ##[1:WK_LAT] hostStat.hostAccessEn) else $error("wake late");
    a_standby_entry_time: assert property (
        int'(sbCnt_reg) > STANDBY_CYC + 3 |-> hostStat.standby)
        else $error("standby late");

    c_store: cover property (nvStoreStart);
    c_asleep: cover property ($rose(hostStat.asleep));
    c_standby: cover property ($rose(hostStat.standby));
endmodule

bind nvsram_store_recall_sequencer nvsram_seq_sva #(
    .LOWEST_VDD_VARIANT(LOWEST_VDD_VARIANT), .SOFT_CMD_CYC(SOFT_CMD_CYC),
    .SLEEP_CYC(SLEEP_CYC), .WAKE_CYC(WAKE_CYC),
    .WAKE_LOWEST_CYC(WAKE_LOWEST_CYC), .STANDBY_CYC(STANDBY_CYC)
) sva_u (
    .mclk(mclk), .rst(rst), .hostReq(hostReq), .hostStat(hostStat),
    .lowVoltageTrip(lowVoltageTrip), .hwStoreBusyNIn(hwStoreBusyNIn),
    .hwStoreBusyNOut(hwStoreBusyNOut), .hwStoreBusyNOe(hwStoreBusyNOe),
    .nvStoreStart(nvStoreStart), .nvRecallStart(nvRecallStart),
    .nvDone(nvDone)
);

// >>> verif/nvsram_store_recall_sequencer_tb.sv
// self-checking bench for the store/recall sequencer
// assumes the package and the cell array stand-in are compiled first
`timescale 1ns/1ps
module nvsram_store_recall_sequencer_tb
    import nvsram_seq_pkg::*;
;
    localparam int SC = 8, SL = 16, WK = 16, SB = 10;
    logic mclk = 1'b0, rst = 1'b1, lowV = 1'b0, extLow = 1'b0, slow = 1'b0;
    logic pinOut, pinOe, stStart, rcStart, done, pinWire, seenOe;
    host_req_t req = '0;
    host_stat_t stat;
    bit autoExp = 1'b1;
    int n_fail = 0, n_tests = 0, seed = 9490, nStore = 0, n, i, s0;

    always #10 mclk = ~mclk;
    // open-drain line with pull-up
    assign pinWire = ((pinOe && !pinOut) || extLow) ? 1'b0 : 1'b1;
    always @(negedge mclk) if (stStart === 1'b1) nStore++;

    nvsram_store_recall_sequencer #(.SOFT_CMD_CYC(SC), .SLEEP_CYC(SL),
        .WAKE_CYC(WK), .WAKE_LOWEST_CYC(32), .STANDBY_CYC(SB)) dut_u (
        .mclk(mclk), .rst(rst), .hostReq(req), .hostStat(stat),
        .lowVoltageTrip(lowV), .hwStoreBusyNIn(pinWire),
        .hwStoreBusyNOut(pinOut), .hwStoreBusyNOe(pinOe),
        .nvStoreStart(stStart), .nvRecallStart(rcStart), .nvDone(done));
    nv_cell_model cell_u (.mclk(mclk), .rst(rst), .slow(slow),
        .storeStart(stStart), .recallStart(rcStart), .done(done));

    task conclude;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task tick;
        @(posedge mclk);
        #2;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp,
            input string msg);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    function logic sel(input int s);
        case (s)
            0: return stat.hostAccessEn;
            1: return stStart;
            2: return stat.asleep;
            3: return stat.standby;
            default: return rcStart;
        endcase
    endfunction
    // whether a triggered store should run
    function int expStore(input bit pend, input bit auto, input bit pin);
        return (pend && (pin || auto)) ? 1 : 0;
    endfunction
    task waitFor(input int s, input int lim, output int cnt);
        cnt = 0;
        while (sel(s) !== 1'b1 && cnt < lim) begin
            tick;
            cnt++;
        end
        if (sel(s) !== 1'b1) begin
            n_fail++;
            $display("BAD %0t wait ran out", $time);
            conclude;
        end
    endtask
    task cmd(input soft_cmd_t c);
        req.cmdValid = 1'b1;
        req.cmd = c;
        tick;
        req.cmdValid = 1'b0;
        tick;
    endtask
    task wr;
        req.sramWrite = 1'b1;
        tick;
        req.sramWrite = 1'b0;
        tick;
    endtask
    // pin or supply-loss trigger held for a random time
    task trig(input bit usePin, input bit pend);
        s0 = nStore;
        seenOe = 1'b0;
        slow = $random(seed) & 1;
        if (usePin) extLow = 1'b1; else lowV = 1'b1;
        repeat (50 + ($random(seed) & 31)) begin
            tick;
            if (pinOe === 1'b1 && !seenOe) begin
                seenOe = 1'b1;
                check(stat.sramWriteEn, 1, "no write grace");
            end
        end
        check(stat.hostAccessEn, 0, "access while held");
        extLow = 1'b0;
        lowV = 1'b0;
        waitFor(0, PIN_RELEASE_CYCLES + 80, n);
        if (usePin) check(n <= PIN_RELEASE_CYCLES, 1, "pin late");
        check(nStore-s0, expStore(pend, autoExp, usePin), "stores");
        check(stat.writePending, 0, "pending left");
        repeat (4) tick;
    endtask

    initial begin
        repeat (10) @(posedge mclk);
        #2;
        rst = 1'b0;
        waitFor(0, 100, n);
        check(stat.autosaveEn, 1, "autosave reset value");
        repeat (($random(seed) & 3) + 1) wr;
        check(stat.writePending, 1, "pending not set");
        cmd(CMD_STORE);
        check(stat.hostAccessEn, 0, "not locked");
        waitFor(1, SC + 4, n);
        check(n <= SC, 1, "store late");
        check(stat.hostAccessEn, 0, "access in store");
        waitFor(0, 60, n);
        check(stat.writePending, 0, "pending after store");
        cmd(CMD_RECALL);
        waitFor(4, SC + 4, n);
        check(n <= SC, 1, "recall late");
        waitFor(0, 60, n);
        repeat (4) tick;
        trig(1'b1, 1'b0);
        wr;
        trig(1'b1, 1'b1);
        cmd(CMD_AUTOSAVE_OFF);
        autoExp = 1'b0;
        repeat (SC + 2) tick;
        check(stat.autosaveEn, 0, "autosave still on");
        wr;
        trig(1'b0, 1'b1);
        cmd(CMD_AUTOSAVE_ON);
        autoExp = 1'b1;
        repeat (SC + 2) tick;
        check(stat.autosaveEn, 1, "autosave still off");
        wr;
        trig(1'b0, 1'b1);
        cmd(CMD_SLEEP);
        waitFor(2, SC + SL + 6, n);
        check(n <= SC + SL + 1, 1, "sleep late");
        req.wakeReq = 1'b1;
        tick;
        req.wakeReq = 1'b0;
        waitFor(0, WK + 10, n);
        check(n <= WK + 1, 1, "wake late");
        tick;
        req.busStop = 1'b1;
        tick;
        req.busStop = 1'b0;
        waitFor(3, SB + 10, n);
        check(n <= SB + 1, 1, "standby late");
        wr;
        check(stat.standby, 0, "standby kept");
        conclude;
    end
endmodule
